// ==== rtl/csc_clock_source_control.sv ====
// How it works
// - Cold reset or sleep exit: RC enabled and selected for the CPU.
// - rc_osc_enable gates RC oscillator running and RC edges into the high divider, not the CPU select.
// - Entering sleep turns the RC oscillator off regardless of settings.
// - rc_bias_keep keeps RC bias on while the oscillator is off.
// - rc_range_select picks the range; one multiplies frequency by ten.
// - Four-bit coarse code scales frequency by code plus one.
// - Cold reset loads fine trim 100000; two upper bits read zero.
// - Warm-up flag clears only after 32768 crystal cycles.
// - crystal_osc_enable stops the crystal oscillator and starts it unless external clock is enabled or detected.
// - Entering sleep stops the crystal oscillator.
// - External clock reaches only the CPU clock path.
// - With external clock enabled, four input pulses flag it detected.
// - 128 Hz tap rising edge raises high irq bit 6, event bit 5.
// - 1 Hz tap rising edge raises mid irq bit 3, event bit 1.
// - CPU select zero picks RC; one picks crystal or external clock.
// - CPU clock source changes other than the forced switch to RC on entering sleep are glitch free.
// - Low divider uses crystal, else the high-divider tap nearest 32 kHz.
`timescale 1ns/1ps
module csc_clock_source_control #(
   parameter int XTAL_WARMUP = csc_pkg::XTAL_WARMUP_CYCLES
) (
   // Clock and reset
   input  wire logic                      ref_clk,
   input  wire logic                      srst,
   // Register port
   input  wire logic [csc_pkg::ADDR_W-1:0] reg_addr,
   input  wire logic [csc_pkg::DATA_W-1:0] reg_wdata,
   input  wire logic                      reg_wr,
   input  wire logic                      reg_rd,
   output logic      [csc_pkg::DATA_W-1:0] reg_rdata,
   // Power mode
   input  wire logic                      sleep_mode,
   // Oscillator and pin clocks
   input  wire logic                      rc_clk_pin,
   input  wire logic                      xtal_clk_pin,
   input  wire logic                      osc_input_pin,
   // Analog oscillator controls
   output logic                           rc_osc_run,
   output logic                           rc_bias_on,
   output logic                           rc_range_out,
   output logic      [3:0]                rc_coarse_out,
   output logic      [5:0]                rc_fine_out,
   output logic                           crystal_osc_run,
   // CPU clock source select, one-hot, all low in the gap
   output logic                           cpu_sel_rc,
   output logic                           cpu_sel_xtal,
   output logic                           cpu_sel_ext,
   output logic                           low_presc_from_xtal,
   // Interrupt and event set pulses
   output logic      [7:0]                high_priority_set,
   output logic      [7:0]                mid_priority_set,
   output logic      [7:0]                event_set
);

   // ----------------------------------------------------------------
   // Tap decoder: high divider bit whose rate is nearest 32 kHz
   // ----------------------------------------------------------------
   function automatic logic [2:0] tap_nearest(input logic       range,
                                              input logic [3:0] coarse,
                                              input logic [5:0] fine);
      longint f_hz;
      longint tap_hz;
      longint err;
      longint best;
      logic [2:0] k_best;
      f_hz   = csc_pkg::RC_MIN_HZ * (range ? csc_pkg::RANGE_FACTOR : 64'd1)
               * (64'(coarse) + 64'd1);
      // Linearised compounding, close enough to pick a power-of-two tap
      f_hz   = f_hz * (64'd1000 + csc_pkg::FINE_STEP_PERMILLE * 64'(fine))
               / 64'd1000;
      best   = 64'h7fffffffffffffff;
      k_best = 3'h0;
      for (int k = 0; k < csc_pkg::HI_PRESC_W; k++) begin
         tap_hz = f_hz >> (k + 1);
         err    = (tap_hz > csc_pkg::LOW_PRESC_HZ) ?
                  tap_hz - csc_pkg::LOW_PRESC_HZ :
                  csc_pkg::LOW_PRESC_HZ - tap_hz;
         if (err < best) begin
            best   = err;
            k_best = 3'(k);
         end
      end
      return k_best;
   endfunction

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic [2:0] pin_rise;

   csc_edge_sync #(.N(3)) u_sync (
      .ref_clk (ref_clk),
      .srst    (srst),
      .pin_in  ({osc_input_pin, xtal_clk_pin, rc_clk_pin}),
      .rise    (pin_rise)
   );

   wire rc_edge   = pin_rise[0];
   wire xtal_edge = pin_rise[1];
   wire ext_edge  = pin_rise[2];

   // ----------------------------------------------------------------
   // Register state
   // ----------------------------------------------------------------
   logic        cpu_sel_r;
   logic        ext_det_r;
   logic        ext_en_r;
   logic        bias_keep_r;
   logic        xt_warm_r;
   logic        rc_cold_r;
   logic        xt_en_r;
   logic        rc_en_r;
   logic        rsvd_r;
   logic        range_r;
   logic [3:0]  coarse_r;
   logic [5:0]  fine_r;
   logic [2:0]  ext_cnt_r;
   logic [15:0] warm_cnt_r;
   logic [7:0]  rdata_r;

   // Cold reset plus sleep resets the sleep-domain fields
   wire rst_sleep = srst | sleep_mode;

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   wire wr_sys   = reg_wr & (reg_addr == csc_pkg::OFS_SYS_CLOCK);
   wire wr_trim1 = reg_wr & (reg_addr == csc_pkg::OFS_RANGE_COARSE);
   wire wr_fine  = reg_wr & (reg_addr == csc_pkg::OFS_FINE);
   wire wr_presc = reg_wr & (reg_addr == csc_pkg::OFS_PRESC);

   wire wd_cpu_sel = reg_wdata[csc_pkg::BIT_CPU_SEL];
   wire wd_xt_en   = reg_wdata[csc_pkg::BIT_XT_EN];
   wire wd_rc_en   = reg_wdata[csc_pkg::BIT_RC_EN];

   // A set of crystal enable is dropped during external clock use
   wire xt_blocked = ext_en_r | ext_det_r;
   wire xt_en_nxt  = wd_xt_en & ~(xt_blocked & ~xt_en_r);
   wire xt_start   = wr_sys & xt_en_nxt & ~xt_en_r;

   // ----------------------------------------------------------------
   // Sleep-domain control bits
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (rst_sleep) begin
         cpu_sel_r <= csc_pkg::RST_CPU_SEL;
         rc_en_r   <= csc_pkg::RST_RC_EN;
         xt_en_r   <= csc_pkg::RST_XT_EN;
      end else if (wr_sys) begin
         cpu_sel_r <= wd_cpu_sel;
         // Clearing RC while it still clocks the CPU is software's hazard
         rc_en_r   <= wd_rc_en;
         xt_en_r   <= xt_en_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Cold-domain control bits
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         ext_en_r    <= csc_pkg::RST_EXT_EN;
         bias_keep_r <= csc_pkg::RST_BIAS_KEEP;
         rsvd_r      <= 1'b0;
         range_r     <= csc_pkg::RST_RANGE;
         coarse_r    <= csc_pkg::RST_COARSE;
         fine_r      <= csc_pkg::RST_FINE;
      end else begin
         if (wr_sys) begin
            ext_en_r    <= reg_wdata[csc_pkg::BIT_EXT_EN];
            bias_keep_r <= reg_wdata[csc_pkg::BIT_BIAS_KEEP];
         end
         if (wr_trim1) begin
            rsvd_r   <= reg_wdata[csc_pkg::BIT_RSVD];
            range_r  <= reg_wdata[csc_pkg::BIT_RANGE];
            coarse_r <= reg_wdata[3:0];
         end
         if (wr_fine) begin
            fine_r <= reg_wdata[5:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // External clock detection
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (srst || !ext_en_r) begin
         ext_cnt_r <= 3'h0;
         ext_det_r <= 1'b0;
      end else if (ext_edge && !ext_det_r) begin
         ext_cnt_r <= ext_cnt_r + 3'h1;
         if (ext_cnt_r + 3'h1 == csc_pkg::EXT_DETECT_PULSES) begin
            ext_det_r <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Crystal warm-up
   // ----------------------------------------------------------------
   localparam logic [15:0] WARM_LAST = 16'(XTAL_WARMUP - 1);

   always_ff @(posedge ref_clk) begin
      if (rst_sleep) begin
         warm_cnt_r <= 16'h0000;
         xt_warm_r  <= csc_pkg::RST_XT_WARM;
      end else if (xt_start) begin
         warm_cnt_r <= 16'h0000;
         xt_warm_r  <= 1'b1;
      end else if (!xt_en_r) begin
         warm_cnt_r <= 16'h0000;
         xt_warm_r  <= 1'b1;
      end else if (xt_warm_r && xtal_edge) begin
         if (warm_cnt_r == WARM_LAST) begin
            xt_warm_r <= 1'b0;
         end else begin
            warm_cnt_r <= warm_cnt_r + 16'h0001;
         end
      end
   end

   // RC start phase ends on the first RC edge seen while running
   always_ff @(posedge ref_clk) begin
      if (rst_sleep || !rc_en_r) begin
         rc_cold_r <= csc_pkg::RST_RC_COLD;
      end else if (rc_edge) begin
         rc_cold_r <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Oscillator control outputs
   // ----------------------------------------------------------------
   logic rc_run_r;
   logic rc_bias_r;
   logic xt_run_r;

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         rc_run_r  <= 1'b0;
         rc_bias_r <= 1'b0;
         xt_run_r  <= 1'b0;
      end else begin
         rc_run_r  <= rc_en_r & ~sleep_mode;
         rc_bias_r <= (rc_en_r & ~sleep_mode) | bias_keep_r;
         xt_run_r  <= xt_en_r & ~sleep_mode;
      end
   end

   // ----------------------------------------------------------------
   // Prescalers
   // ----------------------------------------------------------------
   logic [csc_pkg::HI_PRESC_W-1:0] hi_presc_r;
   logic [csc_pkg::LO_PRESC_W-1:0] lo_presc_r;
   logic                           tap_prev_r;
   logic                           low_xtal_r;

   // Crystal feeds the low divider only when usable; never the pin clock
   wire xtal_ok  = xt_en_r & ~ext_en_r & ~ext_det_r;
   wire [2:0] tap_k = tap_nearest(range_r, coarse_r, fine_r);
   wire hi_tap   = hi_presc_r[tap_k];
   wire hi_tick  = hi_tap & ~tap_prev_r;
   wire lo_tick  = xtal_ok ? xtal_edge : hi_tick;
   wire lo_clear = (wr_presc & reg_wdata[csc_pkg::BIT_PRESC_RST]) | xt_start;

   always_ff @(posedge ref_clk) begin
      if (rst_sleep) begin
         hi_presc_r <= '0;
         tap_prev_r <= 1'b0;
      end else begin
         // RC edges reach the divider only while the RC is enabled
         if (rc_en_r && rc_edge) begin
            hi_presc_r <= hi_presc_r + 8'h01;
         end
         tap_prev_r <= hi_tap;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst_sleep || lo_clear) begin
         lo_presc_r <= '0;
      end else if (lo_tick) begin
         lo_presc_r <= lo_presc_r + 15'h0001;
      end
   end

   // ----------------------------------------------------------------
   // Tap edges to interrupt and event pulses
   // ----------------------------------------------------------------
   logic       fast_prev_r;
   logic       slow_prev_r;
   logic [7:0] hig_r;
   logic [7:0] mid_r;
   logic [7:0] evn_r;

   wire fast_rise = lo_presc_r[csc_pkg::TAP_FAST_BIT] & ~fast_prev_r;
   wire slow_rise = lo_presc_r[csc_pkg::TAP_SLOW_BIT] & ~slow_prev_r;

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         fast_prev_r <= 1'b0;
         slow_prev_r <= 1'b0;
         hig_r       <= 8'h00;
         mid_r       <= 8'h00;
         evn_r       <= 8'h00;
      end else begin
         fast_prev_r <= lo_presc_r[csc_pkg::TAP_FAST_BIT];
         slow_prev_r <= lo_presc_r[csc_pkg::TAP_SLOW_BIT];
         hig_r       <= 8'h00;
         mid_r       <= 8'h00;
         evn_r       <= 8'h00;
         hig_r[csc_pkg::IRQ_HIGH_BIT] <= fast_rise;
         evn_r[csc_pkg::EVT_FAST_BIT] <= fast_rise;
         mid_r[csc_pkg::IRQ_MID_BIT]  <= slow_rise;
         evn_r[csc_pkg::EVT_SLOW_BIT] <= slow_rise;
      end
   end

   // ----------------------------------------------------------------
   // CPU clock source selector
   // ----------------------------------------------------------------
   // Break before make: all selects drop for a gap so the old clock
   // cannot be cut mid-pulse while the new one is joined
   csc_pkg::csc_src_t src_r;
   csc_pkg::csc_src_t src_want;
   csc_pkg::csc_src_t last_r;
   logic [1:0]        gap_cnt_r;

   assign src_want = !cpu_sel_r ? csc_pkg::SRC_RC :
                     xtal_ok    ? csc_pkg::SRC_XTAL :
                                  csc_pkg::SRC_EXT;

   always_ff @(posedge ref_clk) begin
      if (rst_sleep) begin
         src_r     <= csc_pkg::SRC_RC;
         last_r    <= csc_pkg::SRC_RC;
         gap_cnt_r <= 2'h0;
      end else begin
         unique case (src_r)
            csc_pkg::SRC_GAP: begin
               if (gap_cnt_r == csc_pkg::GAP_CYCLES - 2'h1) begin
                  src_r     <= last_r;
                  gap_cnt_r <= 2'h0;
               end else begin
                  gap_cnt_r <= gap_cnt_r + 2'h1;
               end
            end
            csc_pkg::SRC_RC, csc_pkg::SRC_XTAL, csc_pkg::SRC_EXT: begin
               if (src_want != src_r) begin
                  src_r  <= csc_pkg::SRC_GAP;
                  last_r <= src_want;
               end
            end
            default: begin
               src_r <= csc_pkg::SRC_RC;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Read path, one cycle after the strobe
   // ----------------------------------------------------------------
   wire [7:0] sys_rd = {cpu_sel_r, ext_det_r, ext_en_r, bias_keep_r,
                        xt_warm_r, rc_cold_r, xt_en_r, rc_en_r};
   wire [7:0] trim1_rd = {2'b00, rsvd_r, range_r, coarse_r};
   wire [7:0] fine_rd  = {2'b00, fine_r};
   wire [7:0] rd_mux   =
      (reg_addr == csc_pkg::OFS_SYS_CLOCK)    ? sys_rd   :
      (reg_addr == csc_pkg::OFS_RANGE_COARSE) ? trim1_rd :
      (reg_addr == csc_pkg::OFS_FINE)         ? fine_rd  :
                                                8'h00;

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         rdata_r    <= 8'h00;
         low_xtal_r <= 1'b0;
      end else begin
         rdata_r    <= reg_rd ? rd_mux : 8'h00;
         low_xtal_r <= xtal_ok;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign reg_rdata           = rdata_r;
   assign rc_osc_run          = rc_run_r;
   assign rc_bias_on          = rc_bias_r;
   assign rc_range_out        = range_r;
   assign rc_coarse_out       = coarse_r;
   assign rc_fine_out         = fine_r;
   assign crystal_osc_run     = xt_run_r;
   assign cpu_sel_rc          = src_r[0];
   assign cpu_sel_xtal        = src_r[2];
   assign cpu_sel_ext         = src_r[3];
   assign low_presc_from_xtal = low_xtal_r;
   assign high_priority_set   = hig_r;
   assign mid_priority_set    = mid_r;
   assign event_set           = evn_r;

endmodule // csc_clock_source_control

// ==== pkg/csc_pkg.sv ====
package csc_pkg;

   // -----------------------------------------------------------------
   // Register bus
   // -----------------------------------------------------------------
   localparam int          ADDR_W           = 4;
   localparam int          DATA_W           = 8;
   localparam logic [3:0]  OFS_SYS_CLOCK    = 4'h0;
   localparam logic [3:0]  OFS_RANGE_COARSE = 4'h1;
   localparam logic [3:0]  OFS_FINE         = 4'h2;
   localparam logic [3:0]  OFS_PRESC        = 4'h3;

   // -----------------------------------------------------------------
   // Field positions
   // -----------------------------------------------------------------
   localparam int BIT_CPU_SEL   = 7;
   localparam int BIT_EXT_DET   = 6;
   localparam int BIT_EXT_EN    = 5;
   localparam int BIT_BIAS_KEEP = 4;
   localparam int BIT_XT_WARM   = 3;
   localparam int BIT_RC_COLD   = 2;
   localparam int BIT_XT_EN     = 1;
   localparam int BIT_RC_EN     = 0;
   localparam int BIT_RSVD      = 5;
   localparam int BIT_RANGE     = 4;
   localparam int BIT_PRESC_RST = 0;

   // -----------------------------------------------------------------
   // Reset values
   // -----------------------------------------------------------------
   localparam logic       RST_CPU_SEL   = 1'b0;
   localparam logic       RST_EXT_EN    = 1'b0;
   localparam logic       RST_BIAS_KEEP = 1'b1;
   localparam logic       RST_XT_WARM   = 1'b1;
   localparam logic       RST_RC_COLD   = 1'b1;
   localparam logic       RST_XT_EN     = 1'b0;
   localparam logic       RST_RC_EN     = 1'b1;
   localparam logic       RST_RANGE     = 1'b0;
   localparam logic [3:0] RST_COARSE    = 4'h0;
   localparam logic [5:0] RST_FINE      = 6'h20;

   // -----------------------------------------------------------------
   // Counts and taps
   // -----------------------------------------------------------------
   localparam int         XTAL_WARMUP_CYCLES = 32768;
   localparam logic [2:0] EXT_DETECT_PULSES  = 3'h4;
   localparam logic [1:0] GAP_CYCLES         = 2'h2;
   localparam int         HI_PRESC_W         = 8;
   localparam int         LO_PRESC_W         = 15;
   localparam int         TAP_FAST_BIT       = 7;
   localparam int         TAP_SLOW_BIT       = 14;
   localparam int         IRQ_HIGH_BIT       = 6;
   localparam int         EVT_FAST_BIT       = 5;
   localparam int         IRQ_MID_BIT        = 3;
   localparam int         EVT_SLOW_BIT       = 1;

   // Nominal RC figures used by the 32 kHz tap decoder
   localparam longint RC_MIN_HZ          = 80000;
   localparam longint RANGE_FACTOR       = 10;
   localparam longint FINE_STEP_PERMILLE = 14;
   localparam longint LOW_PRESC_HZ       = 32768;

   // -----------------------------------------------------------------
   // CPU clock source selector states
   // -----------------------------------------------------------------
   typedef enum logic [3:0] {
      SRC_RC   = 4'b0001,
      SRC_GAP  = 4'b0010,
      SRC_XTAL = 4'b0100,
      SRC_EXT  = 4'b1000
   } csc_src_t;

endpackage

// ==== rtl/csc_edge_sync.sv ====
`timescale 1ns/1ps
module csc_edge_sync #(
   parameter int N = 3
) (
   // Clock and reset
   input  wire logic         ref_clk,
   input  wire logic         srst,
   // Asynchronous pins
   input  wire logic [N-1:0] pin_in,
   // Synchronised rising-edge pulses
   output logic      [N-1:0] rise
);

   logic [N-1:0] meta_r;
   logic [N-1:0] sync_r;
   logic [N-1:0] prev_r;
   logic [N-1:0] rise_r;

   // ----------------------------------------------------------------
   // Two-stage synchroniser, then an edge detector on the second stage
   // ----------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < N; i++) begin : g_sync
         always_ff @(posedge ref_clk) begin
            if (srst) begin
               meta_r[i] <= 1'b0;
               sync_r[i] <= 1'b0;
               prev_r[i] <= 1'b0;
               rise_r[i] <= 1'b0;
            end else begin
               meta_r[i] <= pin_in[i];
               sync_r[i] <= meta_r[i];
               prev_r[i] <= sync_r[i];
               rise_r[i] <= sync_r[i] & ~prev_r[i];
            end
         end
      end
   endgenerate

   assign rise = rise_r;

endmodule // csc_edge_sync

// ==== bench/csc_chk.sv ====
`timescale 1ns/1ps
module csc_chk (
   // Clock, reset and bus
   input wire logic       ref_clk, srst, sleep_mode, reg_wr, reg_rd,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata, reg_rdata,
   // Watched outputs
   input wire logic       rc_osc_run, crystal_osc_run,
   input wire logic       cpu_sel_rc, cpu_sel_xtal, cpu_sel_ext,
   input wire logic [5:0] rc_fine_out,
   input wire logic [7:0] high_priority_set, mid_priority_set, event_set
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);
   property p_rc_sleep; sleep_mode [*2] |-> !rc_osc_run; endproperty
   a_rc_sleep: assert property (p_rc_sleep)
      else $error("rc runs in sleep");
   property p_xt_sleep; crystal_osc_run |-> !$past(sleep_mode); endproperty
   a_xt_sleep: assert property (p_xt_sleep)
      else $error("crystal runs in sleep");
   property p_sel_sleep; sleep_mode [*3] |-> cpu_sel_rc; endproperty
   a_sel_sleep: assert property (p_sel_sleep)
      else $error("rc not selected in sleep");
   property p_onehot;
      $onehot0({cpu_sel_rc, cpu_sel_xtal, cpu_sel_ext});
   endproperty
   a_onehot: assert property (p_onehot)
      else $error("two cpu sources at once");
   property p_gap;
      $fell(cpu_sel_rc) |-> !(cpu_sel_xtal || cpu_sel_ext) [*2];
   endproperty
   a_gap: assert property (p_gap)
      else $error("no gap after rc release");
   property p_new; $rose(cpu_sel_xtal) |-> !$past(cpu_sel_rc, 2); endproperty
   a_new: assert property (p_new)
      else $error("crystal taken without gap");
   property p_fine_wr;
      reg_wr && reg_addr == csc_pkg::OFS_FINE
         |=> rc_fine_out == $past(reg_wdata[5:0]);
   endproperty
   a_fine_wr: assert property (p_fine_wr)
      else $error("fine trim not applied");
   property p_fine_rd;
      reg_rd && reg_addr == csc_pkg::OFS_FINE |=> reg_rdata[7:6] == 2'b00;
   endproperty
   a_fine_rd: assert property (p_fine_rd)
      else $error("fine upper bits not zero");
   property p_fast; high_priority_set[6] == event_set[5]; endproperty
   a_fast: assert property (p_fast)
      else $error("fast irq and event differ");
   property p_fast_pulse;
      high_priority_set[6] |=> !high_priority_set[6];
   endproperty
   a_fast_pulse: assert property (p_fast_pulse)
      else $error("fast irq longer than one cycle");
   property p_slow; mid_priority_set[3] == event_set[1]; endproperty
   a_slow: assert property (p_slow)
      else $error("slow irq and event differ");
endmodule // csc_chk
bind csc_clock_source_control csc_chk u_chk (.ref_clk, .srst, .sleep_mode,
   .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .rc_osc_run,
   .crystal_osc_run, .cpu_sel_rc, .cpu_sel_xtal, .cpu_sel_ext, .rc_fine_out,
   .high_priority_set, .mid_priority_set, .event_set);

// ==== bench/csc_osc_model.sv ====
`timescale 1ns/1ps
module csc_osc_model (
   // Run controls
   input wire logic ref_clk, rc_run, xt_run, ext_on,
   // Source clocks, frozen while stopped
   output logic     rc_clk, xt_clk, ext_clk
);
   int n;
   // Unrelated periods of 8, 10 and 12 cycles keep pulses above sync width
   initial begin
      {rc_clk, xt_clk, ext_clk} = 3'b000;
      n = 0;
      forever begin
         @(posedge ref_clk);
         n++;
         if (rc_run && n % 4 == 0) rc_clk <= !rc_clk;
         if (xt_run && n % 5 == 0) xt_clk <= !xt_clk;
         if (ext_on && n % 6 == 0) ext_clk <= !ext_clk;
      end
   end
endmodule // csc_osc_model

// ==== bench/clock_source_control_tb_top.sv ====
`timescale 1ns/1ps
module clock_source_control_tb_top;
   logic        ref_clk, srst, reg_wr, reg_rd, sleep_mode, ext_on, rd_d;
   logic        rc_run, xt_run, rc_clk, xt_clk, ext_clk;
   logic        rng, bias, lpx, s_rc, s_xt, s_ex;
   logic [3:0]  crs;
   logic [3:0]  reg_addr;
   logic [7:0]  reg_wdata, reg_rdata, v, hps;
   logic [15:0] exp_q[$], pend;
   int          miscompares, n_compared, n_fast, seed;
   csc_clock_source_control #(.XTAL_WARMUP(8)) DUT (.ref_clk, .srst,
      .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .sleep_mode,
      .rc_clk_pin(rc_clk), .xtal_clk_pin(xt_clk), .osc_input_pin(ext_clk),
      .rc_osc_run(rc_run), .rc_bias_on(bias), .rc_range_out(rng),
      .rc_coarse_out(crs), .rc_fine_out(), .crystal_osc_run(xt_run),
      .cpu_sel_rc(s_rc), .cpu_sel_xtal(s_xt), .cpu_sel_ext(s_ex),
      .low_presc_from_xtal(lpx),
      .high_priority_set(hps), .mid_priority_set(), .event_set());
   csc_osc_model u_osc (.ref_clk, .rc_run, .xt_run, .ext_on, .rc_clk,
      .xt_clk, .ext_clk);
   // ----------------------------------------------------------------
   // Bus tasks and checking
   // ----------------------------------------------------------------
   task automatic check(input logic [7:0] seen, exp);
      n_compared++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   // Mask hides the rc start-phase bit where its timing is loose
   task automatic rd(input logic [3:0] a, input logic [7:0] e, m);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      exp_q.push_back({m, e});
      @(posedge ref_clk);
      reg_rd <= 1'b0;
   endtask
   task automatic final_report;
      $display("Compared %0d, mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   always @(posedge ref_clk) rd_d <= reg_rd;
   always @(posedge ref_clk) if (hps[6] === 1'b1) n_fast++;
   always @(negedge ref_clk)
      if (rd_d === 1'b1) begin
         pend = exp_q.pop_front();
         check(reg_rdata & pend[15:8], pend[7:0]);
      end
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = !ref_clk;
   end
   initial begin
      #80000;
      miscompares++;
      final_report;
   end
   initial begin
      {srst, reg_wr, reg_rd, sleep_mode, ext_on} = 5'b10000;
      reg_addr = 4'h0;
      reg_wdata = 8'h00;
      {miscompares, n_compared, n_fast} = '0;
      seed = 32'h5082fa20;
      repeat (6) @(posedge ref_clk);
      srst <= 1'b0;
      rd(4'h0, 8'h1d, 8'hff);
      rd(4'h2, 8'h20, 8'hff);
      v = $random(seed);
      wr(4'h2, v);
      rd(4'h2, {2'b00, v[5:0]}, 8'hff);
      v = $random(seed);
      wr(4'h1, v);
      rd(4'h1, v & 8'h3f, 8'hff);
      @(negedge ref_clk);
      check({3'b000, rng, crs}, v & 8'h1f);
      rd(4'h9, 8'h00, 8'hff);
      wr(4'h0, 8'h13);
      rd(4'h0, 8'h1b, 8'hfb);
      repeat (300) @(posedge ref_clk);
      rd(4'h0, 8'h13, 8'hff);
      wr(4'h0, 8'h93);
      wr(4'h0, 8'h92);
      // Clearing the low divider pushes the next fast tap past 1100 cycles
      wr(4'h3, 8'h01);
      @(negedge ref_clk);
      check({5'b0, s_ex, s_xt, s_rc}, 8'h02);
      check({5'b0, bias, rc_run, lpx}, 8'h05);
      n_fast = 0;
      repeat (1100) @(posedge ref_clk);
      check(8'(n_fast), 8'h00);
      repeat (300) @(posedge ref_clk);
      check(8'(n_fast), 8'h01);
      rd(4'h0, 8'h92, 8'hfb);
      wr(4'h0, 8'ha0);
      ext_on <= 1'b1;
      repeat (100) @(posedge ref_clk);
      wr(4'h0, 8'ha2);
      rd(4'h0, 8'he8, 8'hfb);
      @(negedge ref_clk);
      check({5'b0, s_ex, s_xt, s_rc}, 8'h04);
      check({5'b0, bias, rc_run, lpx}, 8'h00);
      @(posedge ref_clk);
      sleep_mode <= 1'b1;
      repeat (5) @(posedge ref_clk);
      sleep_mode <= 1'b0;
      rd(4'h0, 8'h69, 8'hfb);
      @(negedge ref_clk);
      check({4'b0, rc_run, s_ex, s_xt, s_rc}, 8'h09);
      repeat (3) @(posedge ref_clk);
      final_report;
   end
endmodule // clock_source_control_tb_top
